/* File: rtl/addr_mode_params.svh */
// constants for address recognition and mode selection
`ifndef ADDR_MODE_PARAMS_SVH
`define ADDR_MODE_PARAMS_SVH

// fixed upper bits of the strapped slave address
`define ADDR_CONST_BITS   3'h2
// broadcast address in autonomous extended mode
`define GLOBAL_AUTO_ADDR  7'h00
// broadcast address in host-managed modes
`define GLOBAL_HOST_ADDR  7'h30
// alert response address, host-managed modes only
`define ALERT_RESP_ADDR   7'h0C
// register byte offsets
`define REG_CTRL_OFS      8'h00
`define REG_STATUS_OFS    8'h04
// control fields and reset value
`define CTRL_INT_EN_BIT   0
`define CTRL_RESET        1'h0
// status fields
`define STS_ADDR_LSB      0
`define STS_MODE_LSB      8
`define STS_HOST_BIT      10
`define STS_INT_BIT       11
`define STS_STATE_LSB     12
`define STS_LATCH_BIT     15
`define STS_GLOBAL_BIT    16
`define STS_WRITE_BIT     17
`define STS_COUNT_LSB     24
// bits per serial byte
`define BYTE_BITS         4'h8
// wait cycles after reset release before the strap capture edge (two sync stages)
`define STRAP_SETTLE      2'h2

`endif

/* File: rtl/addr_mode_pkg.sv */
// types shared by the address recognition block
package addr_mode_pkg;

  typedef enum logic [1:0] {
    MODE_AUTO     = 2'b00,
    MODE_HOST     = 2'b01,
    MODE_RSVD     = 2'b10,
    MODE_HOST_ALT = 2'b11
  } mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK  = 3'b010,
    ST_SEND = 3'b011,
    ST_MACK = 3'b100,
    ST_WAIT = 3'b101
  } state_t;

endpackage

/* File: rtl/pin_sync.sv */
// two-flop synchronisers for pins from outside the clock domain
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] pin_sync
);

  initial begin
    if (WIDTH < 1) $error("pin_sync width must be at least one");
  end

  // one pair of flops per bit; first stage feeds only the second
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        meta        <= 1'b0;
        pin_sync[i] <= 1'b0;
      end else begin
        meta        <= pin[i];
        pin_sync[i] <= meta;
      end
    end
  end

endmodule

/* File: rtl/strap_decode.sv */
// captures straps after reset and decodes address and mode
`timescale 1ns/100ps
`include "addr_mode_params.svh"
module strap_decode (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic [3:0]           strap,
  input  wire logic [1:0]           mode_pins,
  output logic      [6:0]           own_addr,
  output addr_mode_pkg::mode_t      mode,
  output logic      [6:0]           global_addr,
  output logic                      host_managed,
  output logic                      latched
);

  logic [1:0] settle;

  // wait for the sync stages, then capture once until reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle       <= 2'h0;
      latched      <= 1'b0;
      own_addr     <= 7'h00;
      mode         <= addr_mode_pkg::MODE_AUTO;
      global_addr  <= `GLOBAL_AUTO_ADDR;
      host_managed <= 1'b0;
    end else if (!latched) begin
      if (settle != `STRAP_SETTLE) begin
        settle <= settle + 2'h1;
      end else begin
        latched  <= 1'b1;
        own_addr <= {`ADDR_CONST_BITS, strap};
        mode     <= addr_mode_pkg::mode_t'(mode_pins);
        // host-managed modes use the other broadcast address
        if (mode_pins[0]) begin
          global_addr  <= `GLOBAL_HOST_ADDR;
          host_managed <= 1'b1;
        end else begin
          global_addr  <= `GLOBAL_AUTO_ADDR;
          host_managed <= 1'b0;
        end
      end
    end
  end

  const_bits_a: assert property (@(posedge hclk) disable iff (!hresetn)
    latched |-> own_addr[6:4] == `ADDR_CONST_BITS)
    else $error("upper address bits not constant");

  held_stable_a: assert property (@(posedge hclk) disable iff (!hresetn)
    latched |=> $stable(own_addr) && $stable(mode) && latched)
    else $error("decoded address or mode changed");

endmodule

/* File: rtl/slave_address_mode_select.sv */
// serial slave address recognition, mode select and register port
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
`include "addr_mode_params.svh"
module slave_address_mode_select (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        addr_strap_bit3,
  input  wire logic        addr_strap_bit2,
  input  wire logic        addr_strap_bit1,
  input  wire logic        addr_strap_bit0,
  input  wire logic        mode_pin1,
  input  wire logic        mode_pin0,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        int_req,
  output logic             int_out,
  output logic             access_pulse,
  output logic             access_write,
  output logic             access_global,
  output logic             host_managed
);

  logic [7:0]                sync_q;
  logic                      scl_s;
  logic                      sda_s;
  logic                      scl_d;
  logic                      sda_d;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_cond;
  logic                      stop_cond;
  logic [6:0]                own_addr;
  logic [6:0]                global_addr;
  logic                      latched;
  logic                      host_mode;
  addr_mode_pkg::mode_t      mode;
  addr_mode_pkg::state_t     state;
  logic [3:0]                bit_cnt;
  logic [7:0]                shift;
  logic [7:0]                tx;
  logic                      master_ack;
  logic                      hit_own;
  logic                      hit_global;
  logic                      hit_alert;
  logic                      ctrl_int_en;
  logic                      int_en_eff;
  logic                      dp_write;
  logic [7:0]                dp_addr;
  logic                      ap_valid;
  logic [7:0]                access_cnt;
  logic [31:0]               status;

  // strap, mode and bus line pins cross two flops first (int_req does not); one clock
  pin_sync #(
    .WIDTH (8)
  ) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .pin      ({addr_strap_bit3, addr_strap_bit2, addr_strap_bit1,
                addr_strap_bit0, mode_pin1, mode_pin0, scl_in, sda_in}),
    .pin_sync (sync_q)
  );

  assign scl_s = sync_q[1];
  assign sda_s = sync_q[0];

  // address and mode captured once after reset release, then held
  strap_decode u_strap (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .strap        (sync_q[7:4]),
    .mode_pins    (sync_q[3:2]),
    .own_addr     (own_addr),
    .mode         (mode),
    .global_addr  (global_addr),
    .host_managed (host_mode),
    .latched      (latched)
  );

  // previous line levels for edge and condition detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise   = scl_s && !scl_d;
  assign scl_fall   = !scl_s && scl_d;
  assign start_cond = scl_s && scl_d && sda_d && !sda_s;
  assign stop_cond  = scl_s && scl_d && !sda_d && sda_s;

  // address decode of the received control byte
  assign hit_own    = shift[7:1] == own_addr;
  assign hit_global = shift[7:1] == global_addr && !shift[0];
  assign hit_alert  = host_mode && shift[7:1] == `ALERT_RESP_ADDR
                      && shift[0] && int_out;

  // serial slave state machine, stalled until straps are latched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state      <= addr_mode_pkg::ST_IDLE;
      bit_cnt    <= 4'h0;
      shift      <= 8'h00;
      tx         <= 8'h00;
      sda_oe     <= 1'b0;
      master_ack <= 1'b0;
    end else if (!latched) begin
      state  <= addr_mode_pkg::ST_IDLE;
      sda_oe <= 1'b0;
    end else if (start_cond) begin
      state   <= addr_mode_pkg::ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe  <= 1'b0;
    end else if (stop_cond) begin
      state  <= addr_mode_pkg::ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        addr_mode_pkg::ST_ADDR: begin
          if (scl_rise && bit_cnt != `BYTE_BITS) begin
            shift   <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == `BYTE_BITS) begin
            if (hit_own || hit_global || hit_alert) begin
              sda_oe <= 1'b1;
              state  <= addr_mode_pkg::ST_ACK;
            end else begin
              state <= addr_mode_pkg::ST_WAIT;
            end
          end
        end
        addr_mode_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (shift[0] && shift[7:1] == `ALERT_RESP_ADDR) begin
              tx      <= {own_addr, 1'b0};
              sda_oe  <= ~own_addr[6];
              bit_cnt <= 4'h1;
              state   <= addr_mode_pkg::ST_SEND;
            end else begin
              sda_oe <= 1'b0;
              state  <= addr_mode_pkg::ST_WAIT;
            end
          end
        end
        addr_mode_pkg::ST_SEND: begin
          if (scl_fall) begin
            if (bit_cnt == `BYTE_BITS) begin
              sda_oe <= 1'b0;
              state  <= addr_mode_pkg::ST_MACK;
            end else begin
              tx      <= {tx[6:0], 1'b0};
              sda_oe  <= ~tx[6];
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        addr_mode_pkg::ST_MACK: begin
          if (scl_rise) begin
            master_ack <= !sda_s;
          end else if (scl_fall) begin
            // another copy of the address while the master acks
            if (master_ack) begin
              tx      <= {own_addr, 1'b0};
              sda_oe  <= ~own_addr[6];
              bit_cnt <= 4'h1;
              state   <= addr_mode_pkg::ST_SEND;
            end else begin
              state <= addr_mode_pkg::ST_WAIT;
            end
          end
        end
        addr_mode_pkg::ST_WAIT: begin
          sda_oe <= 1'b0;
        end
        default: begin
          state  <= addr_mode_pkg::ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // open-drain line only ever pulled low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // accepted access reported to the byte layer as the ack slot begins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      access_pulse  <= 1'b0;
      access_write  <= 1'b0;
      access_global <= 1'b0;
      access_cnt    <= 8'h00;
    end else begin
      access_pulse <= 1'b0;
      if (latched && !start_cond && !stop_cond
          && state == addr_mode_pkg::ST_ADDR && scl_fall
          && bit_cnt == `BYTE_BITS && (hit_own || hit_global)) begin
        access_pulse  <= 1'b1;
        access_write  <= !shift[0];
        access_global <= !hit_own;
        access_cnt    <= access_cnt + 8'h01;
      end
    end
  end

  // interrupt output; autonomous mode needs software enable
  assign int_en_eff = ctrl_int_en || host_mode;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_out      <= 1'b0;
      host_managed <= 1'b0;
    end else begin
      int_out      <= int_req && int_en_eff && latched;
      host_managed <= host_mode;
    end
  end

  // bus address phase accepted
  assign ap_valid = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end else begin
      dp_write <= ap_valid && hwrite;
      dp_addr  <= haddr[7:0];
    end
  end

  // control register written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_int_en <= `CTRL_RESET;
    end else if (dp_write && dp_addr == `REG_CTRL_OFS) begin
      ctrl_int_en <= hwdata[`CTRL_INT_EN_BIT];
    end
  end

  // status word gathered from the live block state
  always_comb begin
    status = 32'h0000_0000;
    status[`STS_ADDR_LSB +: 7]  = own_addr;
    status[`STS_MODE_LSB +: 2]  = mode;
    status[`STS_HOST_BIT]       = host_mode;
    status[`STS_INT_BIT]        = int_out;
    status[`STS_STATE_LSB +: 3] = state;
    status[`STS_LATCH_BIT]      = latched;
    status[`STS_GLOBAL_BIT]     = access_global;
    status[`STS_WRITE_BIT]      = access_write;
    status[`STS_COUNT_LSB +: 8] = access_cnt;
  end

  // read data registered at the address phase, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (ap_valid && !hwrite && haddr[7:0] == `REG_CTRL_OFS) begin
        hrdata <= {31'h0000_0000, ctrl_int_en};
      end else if (ap_valid && !hwrite
                   && haddr[7:0] == `REG_STATUS_OFS) begin
        hrdata <= status;
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  auto_global_a: assert property (
    latched && mode == addr_mode_pkg::MODE_AUTO
    |-> global_addr == `GLOBAL_AUTO_ADDR)
    else $error("wrong broadcast address in autonomous mode");

  host_global_a: assert property (
    latched && (mode == addr_mode_pkg::MODE_HOST
    || mode == addr_mode_pkg::MODE_HOST_ALT)
    |-> global_addr == `GLOBAL_HOST_ADDR && host_mode)
    else $error("wrong broadcast address in host mode");

  match_ack_a: assert property (
    state == addr_mode_pkg::ST_ADDR && scl_fall && !start_cond
    && !stop_cond && bit_cnt == `BYTE_BITS && hit_own
    |=> sda_oe && state == addr_mode_pkg::ST_ACK)
    else $error("own address not acknowledged");

  alert_mode_a: assert property (
    $rose(state == addr_mode_pkg::ST_SEND)
    |-> host_mode && $past(int_out))
    else $error("alert reply outside host mode");

  alert_reply_a: assert property (
    state == addr_mode_pkg::ST_ACK && scl_fall && shift[0]
    && shift[7:1] == `ALERT_RESP_ADDR && !start_cond && !stop_cond
    |=> tx == {own_addr, 1'b0} ##0 bit_cnt == 4'h1)
    else $error("alert reply is not own address");

  int_gate_a: assert property (
    !int_en_eff |=> !int_out)
    else $error("interrupt driven while disabled");

  ignore_a: assert property (
    state == addr_mode_pkg::ST_WAIT && !start_cond
    |=> !sda_oe && state != addr_mode_pkg::ST_ACK)
    else $error("unmatched access drove the line");

  global_read_a: assert property (
    access_pulse && access_global |-> access_write)
    else $error("broadcast read accepted");

endmodule

/* File: testbench/i2c_host_model.sv */
// serial bus master model that drives the clock and data lines
`timescale 1ns/100ps
module i2c_host_model (
  input  wire logic hclk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic pull_low;

  // open-drain data line with pull-up: low while either party pulls
  assign sda = ~(pull_low | sda_oe);

  initial begin
    scl      = 1'b1;
    pull_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // start: data falls while the clock stands high
  task automatic start_cond;
    tick(1);
    pull_low <= 1'b1;
    tick(8);
    scl <= 1'b0;
    tick(8);
  endtask

  // stop: data rises while the clock is high, then the bus idles high
  task automatic stop_cond;
    pull_low <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(8);
    pull_low <= 1'b0;
    tick(8);
  endtask

  // one bit: data set while the clock is low, sampled before it falls
  task automatic one_bit(input logic tx, output logic rx);
    pull_low <= ~tx;
    tick(4);
    scl <= 1'b1;
    tick(8);
    rx = sda;
    scl <= 1'b0;
    tick(8);
  endtask

  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                      output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      one_bit(tx[i], b);
      rx[i] = b;
    end
    one_bit(1'b1, b);
    ack = ~b;
  endtask

  // control byte after a start; broadcast reads only when a test asks
  task automatic address(input logic [6:0] a, input logic rd,
                         output logic ack);
    logic [7:0] rx;
    start_cond;
    xfer({a, rd}, rx, ack);
  endtask
endmodule

/* File: testbench/test_slave_address_mode_select.sv */
// self-checking bench for address recognition and mode selection
`timescale 1ns/100ps
module test_slave_address_mode_select;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  strap;
  logic [1:0]  mode;
  logic        scl;
  logic        sda;
  logic        sda_out;
  logic        sda_oe;
  logic        int_req;
  logic        int_out;
  logic        access_pulse;
  logic        access_write;
  logic        access_global;
  logic        host_managed;
  int          fails;
  int          checks_done;
  int          pulses;

  slave_address_mode_select dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .addr_strap_bit3(strap[3]),
    .addr_strap_bit2(strap[2]), .addr_strap_bit1(strap[1]),
    .addr_strap_bit0(strap[0]), .mode_pin1(mode[1]),
    .mode_pin0(mode[0]), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .int_req(int_req),
    .int_out(int_out), .access_pulse(access_pulse),
    .access_write(access_write), .access_global(access_global),
    .host_managed(host_managed)
  );

  i2c_host_model host (
    .hclk(hclk), .sda_oe(sda_oe), .scl(scl), .sda(sda)
  );

  // free-running 100 MHz clock
  always #5 hclk = ~hclk;

  // accepted accesses seen on the one-cycle report strobe
  always @(posedge hclk) begin
    if (access_pulse === 1'b1) begin
      pulses++;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one bus transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  // pins set while in reset, then released for capture
  task automatic do_reset(input logic [3:0] s, input logic [1:0] m);
    @(posedge hclk);
    strap   <= s;
    mode    <= m;
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
  endtask

  // a control byte framed by start and stop, ack compared
  task automatic probe(input logic [6:0] a, input logic rd,
                       input logic exp);
    logic ack;
    host.address(a, rd, ack);
    host.stop_cond;
    chk(32'(ack), 32'(exp));
  endtask

  // address and broadcast set for every mode, straps at the ends
  task automatic t_modes;
    logic [1:0]  m;
    logic [3:0]  s;
    logic [6:0]  own;
    logic [31:0] rd;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      s = 4'(i * 5);
      own = {3'b010, s};
      do_reset(s, m);
      pulses = 0;
      ahb(1'b0, 32'h4, 32'h0, rd);
      chk(rd & 32'h8FFF, {20'h8, 1'b0, m[0], m, 1'b0, own});
      chk(32'(host_managed), 32'(m[0]));
      probe(own, 1'b0, 1'b1);
      probe(7'h00, 1'b0, !m[0]);
      probe(7'h30, 1'b0, m[0]);
      chk(32'({access_global, access_write}), 32'h3);
      probe(own ^ 7'h01, 1'b0, 1'b0);
      probe(7'h0C, 1'b1, 1'b0);
      ahb(1'b0, 32'h4, 32'h0, rd);
      chk(32'(rd[31:24]), 32'h2);
      chk(32'(pulses), 32'h2);
    end
  endtask

  // alert reply, broadcast read and unmatched address in host mode
  task automatic t_alert;
    logic       ack;
    logic [7:0] rx;
    do_reset(4'h9, 2'b01);
    pulses = 0;
    int_req <= 1'b1;
    host.tick(3);
    chk(32'(int_out), 32'h1);
    host.address(7'h0C, 1'b1, ack);
    chk(32'(ack), 32'h1);
    host.xfer(8'hFF, rx, ack);
    chk(32'(rx), 32'h52);
    host.stop_cond;
    probe(7'h30, 1'b1, 1'b0);
    host.address(7'h7F, 1'b0, ack);
    host.xfer(8'h52, rx, ack);
    chk(32'(ack), 32'h0);
    host.stop_cond;
    probe(7'h29, 1'b0, 1'b1);
    chk(32'(pulses), 32'h1);
  endtask

  // interrupt enable, unmapped offset, capture and mid-run reset
  task automatic t_ctrl;
    logic [31:0] rd;
    do_reset(4'h3, 2'b00);
    strap <= 4'hC;
    mode  <= 2'b01;
    host.tick(4);
    chk(32'(int_out), 32'h0);
    probe(7'h0C, 1'b1, 1'b0);
    ahb(1'b0, 32'h0, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b1, 32'h0, 32'h1, rd);
    host.tick(2);
    chk(32'(int_out), 32'h1);
    ahb(1'b1, 32'h8, 32'hFFFFFFFF, rd);
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk(rd, 32'h0);
    chk(32'({hresp, sda_out, hreadyout}), 32'h1);
    ahb(1'b0, 32'h4, 32'h0, rd);
    chk(rd & 32'h87FF, 32'h00008023);
    hresetn <= 1'b0;
    host.tick(2);
    chk(32'({int_out, access_global, host_managed}), 32'h0);
    hresetn <= 1'b1;
    host.tick(6);
    ahb(1'b0, 32'h0, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b0, 32'h4, 32'h0, rd);
    chk(rd & 32'h87FF, 32'h0000852C);
  endtask

  initial begin
    hclk        = 1'b0;
    hresetn     = 1'b0;
    hsel        = 1'b0;
    haddr       = 32'h0;
    htrans      = 2'b00;
    hwrite      = 1'b0;
    hsize       = 3'h2;
    hwdata      = 32'h0;
    strap       = 4'h0;
    mode        = 2'b00;
    int_req     = 1'b0;
    fails       = 0;
    checks_done = 0;
    pulses      = 0;
    t_modes;
    t_alert;
    t_ctrl;
    wrap_up;
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    wrap_up;
  end
endmodule
